// *** hw/uart_rx.v ***
// Asynchronous serial receiver with x16 oversampling, address detect and wake on break.
`timescale 1ns/1ns
// What this block does
// - Sixteen-times sampler feeds per-bit shifter
// - Invert control flips receive pin first
// - Async only when sync clear, port enabled
// - Receive enable gates start; flag sets
// - Ninth bit and errors in status
// - Buffer read returns low eight bits
// - Clearing receive enable clears overrun only; framing error stays
// - Overrun on third character, two unread
// - Address detect needs nine-bit and enable
// - Detect off: every character is loaded
// - Sleep stops baud clock and reception
// - Wake enable suspends reception, watches line
// - Falling line edge is the wake event
// - Wake event sets the receive flag
// - Buffer read clears wake receive flag
// - First rising edge clears wake enable
// - Wake only in asynchronous mode
// - Start, eight or nine bits LSB first, stop
// - Sample clock prescaled x1 or x4 by controls
module uart_rx
(
    // Clock, reset and enable
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        clk_en,
    // Serial line
    input  wire        receive_line,
    // AXI4-Lite write address and data
    input  wire [31:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    // AXI4-Lite read
    input  wire [31:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    // Receive interrupt request
    output reg         receive_irq
);
`include "uart_rx_consts.vh"

localparam ST_IDLE  = 2'h0;
localparam ST_START = 2'h1;
localparam ST_DATA  = 2'h2;
localparam ST_STOP  = 2'h3;

// ----------------------------------------------------------------
// Registers
// ----------------------------------------------------------------
reg [7:0]  rcs_q;
reg [7:0]  txs_q;
reg [7:0]  bdc_q;
reg [7:0]  div_hi_q;
reg [7:0]  div_lo_q;
reg        irq_en_q;
reg        sleep_q;
reg        flag_wake_q;
reg [8:0]  fifo_q [0:1];
reg [1:0]  fifo_fe_q;
reg [1:0]  count_q;
reg        overrun_q;
reg        line_s1_q;
reg        line_s2_q;
reg        line_prev_q;
reg        wake_armed_q;
reg [15:0] brg_cnt_q;
reg [5:0]  pre_q;
reg [3:0]  tick_cnt_q;
reg [1:0]  state_q;
reg [3:0]  bit_idx_q;
reg [8:0]  shift_q;
reg [31:0] awaddr_q;
reg        aw_held_q;
reg [31:0] wdata_q;
reg        w_held_q;

// ----------------------------------------------------------------
// Line conditioning and mode decode
// ----------------------------------------------------------------
// pin inversion
wire line = line_s2_q ^ bdc_q[`BDC_RX_INVERT];
wire async_on = rcs_q[`RCS_SERIAL_PORT_ENABLE] & ~txs_q[`TXS_SYNC_SELECT];
wire continuous_receive_enable     = rcs_q[`RCS_CONT_RECEIVE];
wire nine     = rcs_q[`RCS_NINE_BIT_RECEIVE];
wire wake_on  = bdc_q[`BDC_WAKE_ON_BREAK] & async_on;
wire addr_det = nine & rcs_q[`RCS_ADDRESS_DETECT];
wire fall     = line_prev_q & ~line;
wire rise     = ~line_prev_q & line;

// ----------------------------------------------------------------
// Baud generator
// ----------------------------------------------------------------
// divisor and x1 or x4 prescale
wire [15:0] divisor = bdc_q[`BDC_WIDE_DIVISOR] ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
wire [5:0]  pre_top = txs_q[`TXS_HIGH_SPEED_BAUD] ? 6'h00 : 6'h03;
wire        brg_wrap = (brg_cnt_q == divisor);
wire        run = clk_en & ~sleep_q & async_on;
wire        tick = run & brg_wrap & (pre_q == pre_top);

wire bit_tick = tick & (tick_cnt_q == `MID_SAMPLE);
wire char_done = bit_tick & (state_q == ST_STOP);
// detect on needs ninth bit set
wire keep = ~addr_det | shift_q[8];

// ----------------------------------------------------------------
// Bus decode
// ----------------------------------------------------------------
wire        wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
wire [7:0]  wa = awaddr_q[7:0];
wire        rd_go = s_axi_arvalid & s_axi_arready;
wire [7:0]  ra = s_axi_araddr[7:0];
// Upper address bits must be zero, so a register never answers at an alias.
wire        rd_buf = rd_go & (s_axi_araddr[31:8] == 24'h000000) &
                     (ra == {4'h0, `OFF_RECEIVE_BUFFER});
wire        wr_ok = (awaddr_q[31:8] == 24'h000000) & (
                    (wa == {4'h0, `OFF_RECEIVE_STATUS_CONTROL}) |
                    (wa == {4'h0, `OFF_TRANSMIT_STATUS_CTRL}) |
                    (wa == {4'h0, `OFF_BAUD_CONTROL}) |
                    (wa == {3'h0, `OFF_BAUD_DIVISOR_HIGH}) |
                    (wa == {3'h0, `OFF_BAUD_DIVISOR_LOW}) |
                    (wa == {3'h0, `OFF_PERIPHERAL_IRQ_ENABLES}) |
                    (wa == {2'h0, `OFF_SLEEP_CONTROL}));
wire        rcv_flag = (count_q != 2'h0) | flag_wake_q;
wire [7:0]  rcs_view = {rcs_q[7:3], fifo_fe_q[0], overrun_q, fifo_q[0][8]};

reg [31:0] rd_d;
reg        rd_ok;
always @*
begin
    rd_ok = 1'b1;
    rd_d  = 32'h00000000;
    case (ra)
        {4'h0, `OFF_RECEIVE_STATUS_CONTROL}: rd_d = {24'h000000, rcs_view};
        {4'h0, `OFF_RECEIVE_BUFFER}:         rd_d = {24'h000000, fifo_q[0][7:0]};
        {4'h0, `OFF_TRANSMIT_STATUS_CTRL}:   rd_d = {24'h000000, txs_q};
        {4'h0, `OFF_BAUD_CONTROL}:
            rd_d = {24'h000000, bdc_q[7], (state_q == ST_IDLE), bdc_q[5:0]};
        {3'h0, `OFF_BAUD_DIVISOR_HIGH}:      rd_d = {24'h000000, div_hi_q};
        {3'h0, `OFF_BAUD_DIVISOR_LOW}:       rd_d = {24'h000000, div_lo_q};
        {3'h0, `OFF_PERIPHERAL_IRQ_FLAGS}:   rd_d = {26'h0000000, rcv_flag, 5'h00};
        {3'h0, `OFF_PERIPHERAL_IRQ_ENABLES}: rd_d = {26'h0000000, irq_en_q, 5'h00};
        {2'h0, `OFF_SLEEP_CONTROL}:          rd_d = {31'h00000000, sleep_q};
        default:                             rd_ok = 1'b0;
    endcase
    if (s_axi_araddr[31:8] != 24'h000000)
    begin
        rd_ok = 1'b0;
        rd_d  = 32'h00000000;
    end
end

// ----------------------------------------------------------------
// Bus slave
// ----------------------------------------------------------------
// Address and data are latched independently so either may come first.
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b0;
        s_axi_bresp   <= `AXI_OKAY;
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b0;
        s_axi_rresp   <= `AXI_OKAY;
        s_axi_rdata   <= 32'h00000000;
        aw_held_q     <= 1'b0;
        w_held_q      <= 1'b0;
        awaddr_q      <= 32'h00000000;
        wdata_q       <= 32'h00000000;
    end
    else if (clk_en)
    begin
        s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
        s_axi_wready  <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
        if (s_axi_awvalid & s_axi_awready)
        begin
            aw_held_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
        end
        if (s_axi_wvalid & s_axi_wready)
        begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
        end
        if (wr_go)
        begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_ok ? `AXI_OKAY : `AXI_DECERR;
        end
        else if (s_axi_bvalid & s_axi_bready)
            s_axi_bvalid <= 1'b0;
        s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
        if (rd_go)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_d;
            s_axi_rresp  <= rd_ok ? `AXI_OKAY : `AXI_DECERR;
        end
        else if (s_axi_rvalid & s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Control registers and wake logic
// ----------------------------------------------------------------
wire wr_byte = wr_go & wr_ok & s_axi_wstrb[0];
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        rcs_q        <= `RESET_BYTE;
        txs_q        <= `RESET_BYTE;
        bdc_q        <= `RESET_BYTE;
        div_hi_q     <= `RESET_BYTE;
        div_lo_q     <= `RESET_BYTE;
        irq_en_q     <= 1'b0;
        sleep_q      <= 1'b0;
        flag_wake_q  <= 1'b0;
        wake_armed_q <= 1'b0;
        line_s1_q    <= 1'b1;
        line_s2_q    <= 1'b1;
        line_prev_q  <= 1'b1;
        receive_irq  <= 1'b0;
    end
    else if (clk_en)
    begin
        line_s1_q   <= receive_line;
        line_s2_q   <= line_s1_q;
        line_prev_q <= line;
        receive_irq <= rcv_flag & irq_en_q;
        if (wr_byte)
        begin
            case (wa)
                {4'h0, `OFF_RECEIVE_STATUS_CONTROL}: rcs_q <= {wdata_q[7:3], 3'h0};
                {4'h0, `OFF_TRANSMIT_STATUS_CTRL}:   txs_q <= wdata_q[7:0];
                {4'h0, `OFF_BAUD_CONTROL}:
                    bdc_q <= {1'b0, 1'b0, wdata_q[5:3], 1'b0, wdata_q[1], 1'b0};
                {3'h0, `OFF_BAUD_DIVISOR_HIGH}:      div_hi_q <= wdata_q[7:0];
                {3'h0, `OFF_BAUD_DIVISOR_LOW}:       div_lo_q <= wdata_q[7:0];
                {3'h0, `OFF_PERIPHERAL_IRQ_ENABLES}:
                    irq_en_q <= wdata_q[`PIE_RECEIVE_IRQ_ENABLE];
                {2'h0, `OFF_SLEEP_CONTROL}:          sleep_q <= wdata_q[0];
                default:                             sleep_q <= sleep_q;
            endcase
        end
        if (wake_on & ~wake_armed_q & fall)
            wake_armed_q <= 1'b1;
        else if (wake_armed_q & rise)
        begin
            wake_armed_q           <= 1'b0;
            bdc_q[`BDC_WAKE_ON_BREAK] <= 1'b0;
        end
        // wake sets receive flag, set wins
        if (wake_on & ~wake_armed_q & fall)
            flag_wake_q <= 1'b1;
        else if (rd_buf)
            flag_wake_q <= 1'b0;
    end
end

// ----------------------------------------------------------------
// Receive shifter and two-entry buffer
// ----------------------------------------------------------------
// The edge detector runs on the system clock even while the baud clock is stopped,
// so a break is seen in sleep as well; the sampler itself needs the baud clock.
always @(posedge aclk)
begin
    if (!aresetn)
    begin
        brg_cnt_q  <= 16'h0000;
        pre_q      <= 6'h00;
        tick_cnt_q <= 4'h0;
        state_q    <= ST_IDLE;
        bit_idx_q  <= 4'h0;
        shift_q    <= 9'h000;
        fifo_q[0]  <= 9'h000;
        fifo_q[1]  <= 9'h000;
        fifo_fe_q  <= 2'h0;
        count_q    <= 2'h0;
        overrun_q  <= 1'b0;
    end
    else if (clk_en)
    begin
        if (run)
        begin
            brg_cnt_q <= brg_wrap ? 16'h0000 : brg_cnt_q + 16'h0001;
            if (brg_wrap)
                pre_q <= (pre_q == pre_top) ? 6'h00 : pre_q + 6'h01;
        end
        if (tick)
            tick_cnt_q <= tick_cnt_q + 4'h1;
        if (wake_on | ~run)
        begin
            state_q    <= ST_IDLE;
            tick_cnt_q <= 4'h0;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                    if (continuous_receive_enable & ~overrun_q & fall)
                    begin
                        state_q    <= ST_START;
                        tick_cnt_q <= 4'h0;
                    end
                ST_START:
                    if (bit_tick)
                    begin
                        state_q   <= line ? ST_IDLE : ST_DATA;
                        bit_idx_q <= 4'h0;
                    end
                ST_DATA:
                    // LSB first, eight or nine bits
                    if (bit_tick)
                    begin
                        shift_q   <= nine ? {line, shift_q[8:1]} : {1'b0, line, shift_q[7:1]};
                        bit_idx_q <= bit_idx_q + 4'h1;
                        if (bit_idx_q == (nine ? 4'h8 : 4'h7))
                            state_q <= ST_STOP;
                    end
                ST_STOP:
                    if (bit_tick)
                        state_q <= ST_IDLE;
                default:
                    state_q <= ST_IDLE;
            endcase
        end
        if (!continuous_receive_enable)
            overrun_q <= 1'b0;
        else if (char_done & keep & (count_q == 2'h2))
            overrun_q <= 1'b1;
        if (rd_buf & (count_q != 2'h0))
        begin
            fifo_q[0]    <= fifo_q[1];
            fifo_fe_q[0] <= fifo_fe_q[1];
        end
        if (char_done & keep & continuous_receive_enable & (count_q != 2'h2))
        begin
            if ((count_q == 2'h0) | (rd_buf & (count_q == 2'h1)))
            begin
                fifo_q[0]    <= shift_q;
                fifo_fe_q[0] <= ~line;
            end
            else
            begin
                fifo_q[1]    <= shift_q;
                fifo_fe_q[1] <= ~line;
            end
            if (!(rd_buf & (count_q != 2'h0)))
                count_q <= count_q + 2'h1;
        end
        else if (rd_buf & (count_q != 2'h0))
            count_q <= count_q - 2'h1;
    end
end

endmodule

// *** common/uart_rx_consts.vh ***
// Register offsets, field positions, reset values and timing counts of the serial receiver.
`ifndef UART_RX_CONSTS_VH
`define UART_RX_CONSTS_VH

`define OFF_RECEIVE_STATUS_CONTROL 4'h0
`define OFF_RECEIVE_BUFFER         4'h4
`define OFF_TRANSMIT_STATUS_CTRL   4'h8
`define OFF_BAUD_CONTROL           4'hC
`define OFF_BAUD_DIVISOR_HIGH      5'h10
`define OFF_BAUD_DIVISOR_LOW       5'h14
`define OFF_PERIPHERAL_IRQ_FLAGS   5'h18
`define OFF_PERIPHERAL_IRQ_ENABLES 5'h1C
`define OFF_SLEEP_CONTROL          6'h20

`define RCS_SERIAL_PORT_ENABLE     7
`define RCS_NINE_BIT_RECEIVE       6
`define RCS_CONT_RECEIVE           4
`define RCS_ADDRESS_DETECT         3
`define RCS_FRAMING_ERROR          2
`define RCS_OVERRUN_ERROR          1
`define RCS_NINTH_BIT              0

`define TXS_SYNC_SELECT            4
`define TXS_HIGH_SPEED_BAUD        2

`define BDC_RX_IDLE                6
`define BDC_RX_INVERT              5
`define BDC_WIDE_DIVISOR           3
`define BDC_WAKE_ON_BREAK          1

`define PIR_RECEIVE_FLAG           5
`define PIE_RECEIVE_IRQ_ENABLE     5

`define RESET_BYTE                 8'h00
`define OVERSAMPLE                 5'h10
`define MID_SAMPLE                 4'h7
`define AXI_OKAY                   2'h0
`define AXI_DECERR                 2'h3

`endif

// *** verif/uart_rx_monitor.sv ***
// Bus and reset checks for the serial receiver.
`timescale 1ns/1ns
`include "uart_rx_consts.vh"
module uart_rx_monitor
(
    // Clock and reset
    input wire        aclk,
    input wire        aresetn,
    // Register bus
    input wire [31:0] s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    // Interrupt
    input wire        receive_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
        && !receive_irq) else $error("outputs busy after reset");
    a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read response repeated");
    a_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("address ready held");
    a_rd_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 32'h20
        |=> s_axi_rresp == `AXI_DECERR && s_axi_rdata == 32'h0)
        else $error("unmapped read answered");
    a_rd_mapped: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr <= 32'h20 && s_axi_araddr[1:0] == 2'h0
        |=> s_axi_rresp == `AXI_OKAY && s_axi_rdata[31:8] == 24'h0)
        else $error("mapped read malformed");
    a_wr_decerr: assert property (s_axi_awvalid && s_axi_awready && s_axi_awaddr > 32'h20
        |-> ##[1:2] s_axi_bvalid && s_axi_bresp == `AXI_DECERR)
        else $error("unmapped write answered");
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_decerr: cover property (s_axi_rvalid && s_axi_rresp == `AXI_DECERR);
    c_irq: cover property ($rose(receive_irq));
endmodule
bind uart_rx uart_rx_monitor uart_rx_monitor_inst
(
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .receive_irq
);

// *** verif/far_tx.sv ***
// Remote serial transmitter model driving the receive line.
`timescale 1ns/1ns
module far_tx
(
    // Clock
    input wire  aclk,
    // Serial line
    output wire line
);
    localparam BIT_CLKS = 16;
    reg raw = 1'b1;
    reg inv = 1'b0;
    // An inverted link idles low, so the level follows the polarity setting.
    assign line = raw ^ inv;
    task send(input [11:0] d, input integer n, input stop_bit);
        reg [11:0] sh;
        integer    i;
        begin
            sh = d;
            raw <= 1'b0;
            repeat (BIT_CLKS) @(posedge aclk);
            for (i = 0; i < n; i = i + 1)
            begin
                raw <= sh[0];
                sh = sh >> 1;
                repeat (BIT_CLKS) @(posedge aclk);
            end
            raw <= stop_bit;
            repeat (BIT_CLKS) @(posedge aclk);
            raw <= 1'b1;
            repeat (BIT_CLKS) @(posedge aclk);
        end
    endtask
endmodule

// *** verif/uart_rx_tb.sv ***
// Self-checking bench for the serial receiver.
`timescale 1ns/1ns
`include "uart_rx_consts.vh"
module uart_rx_tb;
    reg         aclk = 1'b0;
    reg         aresetn = 1'b0;
    reg  [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    reg         s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg         s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire        receive_irq, receive_line;
    wire [1:0]  s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    reg  [31:0] rd_data;
    reg  [1:0]  rd_resp, wr_resp;
    integer     n_errors = 0, samples_checked = 0, cycles = 0;
    always #25 aclk = ~aclk;
    uart_rx uart_rx_inst
    (
        .aclk, .aresetn, .clk_en(1'b1), .receive_line,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .receive_irq
    );
    far_tx far_tx_inst
    (
        .aclk,
        .line (receive_line)
    );
    task chk(input [31:0] got, input [31:0] exp);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp)
            begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
            end
        end
    endtask
    task chk_resp(input [1:0] got, input [1:0] exp);
        begin
            chk({30'h0, got}, {30'h0, exp});
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        begin
            @(posedge aclk);
            s_axi_awaddr <= {24'h0, a};
            s_axi_wdata <= {24'h0, d};
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (s_axi_awready)
                    s_axi_awvalid <= 1'b0;
                if (s_axi_wready)
                    s_axi_wvalid <= 1'b0;
            end while (!s_axi_bvalid);
            wr_resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask
    task rd(input [7:0] a);
        begin
            @(posedge aclk);
            s_axi_araddr <= {24'h0, a};
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do
            begin
                @(posedge aclk);
                if (s_axi_arready)
                    s_axi_arvalid <= 1'b0;
            end while (!s_axi_rvalid);
            rd_data = s_axi_rdata;
            rd_resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    task rdc(input [7:0] a, input [7:0] exp, input [7:0] m);
        begin
            rd(a);
            chk(rd_data & {24'hFFFFFF, m}, {24'h0, exp});
        end
    endtask
    task close_out;
        begin
            $display("mismatches %0d, comparisons %0d", n_errors, samples_checked);
            if (n_errors == 0 && samples_checked > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    always @(posedge aclk)
    begin
        cycles = cycles + 1;
        if (cycles == 10000)
        begin
            n_errors = n_errors + 1;
            close_out;
        end
    end
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(8'h00, 8'h00, 8'hFF);
        rdc(8'h04, 8'h00, 8'hFF);
        rd(8'h24);
        chk_resp(rd_resp, `AXI_DECERR);
        wr(8'h24, 8'hFF);
        chk_resp(wr_resp, `AXI_DECERR);
        // Fast sampling: one tick per clock keeps each bit at 16 clocks.
        wr(8'h08, 8'h04);
        wr(8'h1C, 8'h20);
        wr(8'h00, 8'h80);
        far_tx_inst.send(12'h0A5, 8, 1'b1);
        rdc(8'h18, 8'h00, 8'hFF);
        wr(8'h00, 8'h90);
        far_tx_inst.send(12'h0A5, 8, 1'b1);
        chk({31'h0, receive_irq}, 32'h1);
        rdc(8'h18, 8'h20, 8'hFF);
        wr(8'h1C, 8'h00);
        repeat (2) @(posedge aclk);
        chk({31'h0, receive_irq}, 32'h0);
        rdc(8'h04, 8'hA5, 8'hFF);
        rdc(8'h18, 8'h00, 8'hFF);
        wr(8'h20, 8'h01);
        far_tx_inst.send(12'h0C3, 8, 1'b1);
        wr(8'h20, 8'h00);
        rdc(8'h18, 8'h00, 8'hFF);
        far_tx_inst.send(12'h011, 8, 1'b1);
        far_tx_inst.send(12'h022, 8, 1'b1);
        far_tx_inst.send(12'h033, 8, 1'b1);
        rdc(8'h00, 8'h92, 8'hFF);
        rdc(8'h04, 8'h11, 8'hFF);
        rdc(8'h04, 8'h22, 8'hFF);
        wr(8'h00, 8'h80);
        rdc(8'h00, 8'h80, 8'hFF);
        far_tx_inst.inv <= 1'b1;
        wr(8'h0C, 8'h20);
        wr(8'h00, 8'h90);
        far_tx_inst.send(12'h05A, 8, 1'b1);
        rdc(8'h04, 8'h5A, 8'hFF);
        wr(8'h00, 8'h00);
        far_tx_inst.inv <= 1'b0;
        wr(8'h0C, 8'h00);
        wr(8'h00, 8'hD8);
        far_tx_inst.send(12'h055, 9, 1'b1);
        rdc(8'h18, 8'h00, 8'hFF);
        far_tx_inst.send(12'h133, 9, 1'b1);
        rdc(8'h00, 8'hD9, 8'hFF);
        rdc(8'h04, 8'h33, 8'hFF);
        wr(8'h00, 8'hD0);
        far_tx_inst.send(12'h044, 9, 1'b1);
        rdc(8'h00, 8'hD0, 8'hFF);
        rdc(8'h04, 8'h44, 8'hFF);
        wr(8'h00, 8'h90);
        wr(8'h0C, 8'h02);
        far_tx_inst.send(12'h000, 12, 1'b1);
        rdc(8'h18, 8'h20, 8'hFF);
        rdc(8'h0C, 8'h00, 8'h02);
        rdc(8'h00, 8'h90, 8'hFF);
        rd(8'h04);
        rdc(8'h18, 8'h00, 8'hFF);
        far_tx_inst.send(12'h03C, 8, 1'b0);
        rdc(8'h00, 8'h94, 8'hFF);
        rdc(8'h04, 8'h3C, 8'hFF);
        close_out;
    end
endmodule
